/* File: design/rug_pkg.sv */
// Shared constants and types for the remote upgrade register core
package rug_pkg;

	// Control register layout, bit 38 down to bit 0
	typedef struct packed {
		logic reserved_high_bit;
		logic early_done_check_bit;
		logic osc_int_bit;
		logic watchdog_enable_bit;
		logic reserved_low_bit;
		logic [21:0] boot_address_field;
		logic [11:0] watchdog_timeout_field;
	} rug_ctrl_t;

	localparam int unsigned CTRL_W = 39;
	localparam int unsigned WDEN_BIT = 35;
	localparam logic [38:0] CTRL_RST = 39'h78_0000_0000;

	// Power-up factory addresses for the two flash schemes
	localparam logic [23:0] SERIAL_FACTORY_ADDR = 24'h000000;
	localparam logic [23:0] PARALLEL_FACTORY_ADDR = 24'h010000;
	localparam logic [1:0] ADDR_PAD = 2'h0;
	localparam logic [16:0] WDT_LOW = 17'h00008;

	// Reconfiguration source positions, highest wins a tie
	localparam int unsigned SRC_CFG_PIN = 4;
	localparam int unsigned SRC_CRC = 3;
	localparam int unsigned SRC_STATUS = 2;
	localparam int unsigned SRC_WDOG = 1;
	localparam int unsigned SRC_FABRIC = 0;

	// Capture sources
	localparam logic [1:0] RD_CONFIG = 2'h0;
	localparam logic [1:0] RD_CURRENT = 2'h1;
	localparam logic [1:0] RD_PREV1 = 2'h2;
	localparam logic [1:0] RD_PREV2 = 2'h3;
	localparam logic [38:0] BAD_CAPTURE = 39'h7f_ffff_ffff;

	// Synchroniser stages
	localparam int unsigned SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		MS_FACTORY = 2'b00,
		MS_APP_LOAD = 2'b01,
		MS_APP_USER = 2'b11
	} rug_mstate_t;

	typedef struct packed {
		logic [4:0] src;
		logic [1:0] state;
		logic [23:0] addr;
	} rug_prev_t;

	// Word handed to the shift clock domain
	typedef struct packed {
		rug_ctrl_t ctrl;
		logic [31:0] cur_status;
		rug_prev_t prev1;
		rug_prev_t prev2;
		logic prev_valid;
		logic factory;
	} rug_snap_t;

	typedef struct packed {
		rug_mstate_t mstate;
		rug_ctrl_t ctrl;
		rug_ctrl_t update_copy;
		rug_prev_t prev1;
		rug_prev_t prev2;
		logic prev_valid;
		logic [28:0] wdt_cnt;
		logic strap_done;
		logic [23:0] factory_addr;
		logic [23:0] boot_address;
		logic upd_seen;
		logic [4:0] src_q;
		logic reconfig;
		rug_snap_t snap;
		logic snap_tog;
	} rug_sys_st_t;

	typedef struct packed {
		logic [38:0] shift;
		rug_ctrl_t update;
		logic upd_tog;
		rug_snap_t snap;
		logic snap_seen;
	} rug_link_st_t;

endpackage

/* File: design/rug_sync.sv */
// Two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module rug_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Destination clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Data
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [rug_pkg::SYNC_STAGES-1:0][WIDTH-1:0] st;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= {st[rug_pkg::SYNC_STAGES-2:0], d_i};
		end
	end

	assign q_o = st[rug_pkg::SYNC_STAGES-1];
endmodule
`default_nettype wire

/* File: design/rug_core.sv */
// Remote upgrade register core: shift, update, control and status registers
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Shift register reachable from user logic
// - Update writes only in factory configuration
// - Application read loads control into shift
// - Reconfiguration copies update into control
// - Update changes only by shift then update
// - Factory read loads update into shift
// - Status records cause of every reconfiguration
// - Capture loads status into shift
// - Control and status run on oscillator clock
// - Shift and update run on user clock
// - Serial scheme powers up at address zero
// - Parallel scheme powers up at factory default
// - Timeout is field then fixed low pattern
// - Boot address is field with two zeros
// - Bit 35 enables the user watchdog
// - Early check failure reloads factory image
// - Option bit selects internal startup clock
// - Status written on the five sources
// - One-hot source, higher bit wins ties
module rug_core (
	// Oscillator clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// User interface clock
	input wire logic upgrade_shift_clock_i,
	// Serial access, user clock domain
	input wire logic upgrade_serial_in_i,
	input wire logic shift_or_load_select_i,
	input wire logic capture_or_update_select_i,
	input wire logic [1:0] capture_source_i,
	output logic upgrade_serial_out_o,
	// Requests from user logic
	input wire logic fabric_reconfig_request_n_i,
	input wire logic watchdog_restart_n_i,
	// Device pins and loader events
	input wire logic config_reset_pin_n_i,
	input wire logic config_status_line_n_i,
	input wire logic crc_error_i,
	input wire logic config_complete_pin_i,
	input wire logic image_check_fail_i,
	input wire logic parallel_flash_scheme_i,
	// Boundary-scan factory address change
	input wire logic factory_address_set_instr_i,
	input wire logic [23:0] factory_address_i,
	// Configuration outputs
	output logic [23:0] boot_address_o,
	output logic reconfig_start_o,
	output logic factory_mode_o,
	output logic watchdog_enable_o,
	output logic early_check_enable_o,
	output logic startup_clk_internal_o
);
	rug_pkg::rug_sys_st_t st, next_st;
	rug_pkg::rug_link_st_t lk, next_lk;
	logic [8:0] sys_raw, sys_s;
	logic strap_s;
	logic link_snap_tog;
	logic [4:0] ev, src_one;
	logic [28:0] wdt_limit;
	logic early_fail, wdt_expire;
	rug_pkg::rug_snap_t snap_now;

	// Keeps only the highest pending source
	function automatic logic [4:0] rug_first(input logic [4:0] v);
		logic [4:0] f;
		f = '0;
		for (int i = 0; i < 5; i++) begin
			if (v[i]) begin
				f = '0;
				f[i] = 1'b1;
			end
		end
		return f;
	endfunction

	// Active-low lines are inverted ahead of the synchroniser so that its reset reads idle
	assign sys_raw = {lk.snap_seen, lk.upd_tog, image_check_fail_i,
		config_complete_pin_i, crc_error_i, ~config_status_line_n_i, ~config_reset_pin_n_i,
		~watchdog_restart_n_i, ~fabric_reconfig_request_n_i};

	rug_sync #(.WIDTH(9)) u_sys_sync (
		.clk_i(sys_clk_i),
		.rst_i(sys_rst_i),
		.d_i(sys_raw),
		.q_o(sys_s)
	);

	// Strap chain runs through reset, so the scheme is settled at the first edge after it
	rug_sync #(.WIDTH(1)) u_strap_sync (
		.clk_i(sys_clk_i),
		.rst_i(1'h0),
		.d_i(parallel_flash_scheme_i),
		.q_o(strap_s)
	);

	rug_sync #(.WIDTH(1)) u_link_sync (
		.clk_i(upgrade_shift_clock_i),
		.rst_i(sys_rst_i),
		.d_i(st.snap_tog),
		.q_o(link_snap_tog)
	);

	assign wdt_limit = {st.ctrl.watchdog_timeout_field, rug_pkg::WDT_LOW};
	assign wdt_expire = (st.mstate == rug_pkg::MS_APP_USER) && st.ctrl.watchdog_enable_bit
		&& !sys_s[1] && (st.wdt_cnt == wdt_limit);
	// Loader failure is filed under the CRC source
	assign early_fail = (st.mstate == rug_pkg::MS_APP_LOAD) && st.ctrl.early_done_check_bit
		&& sys_s[6];
	always_comb begin
		ev = '0;
		ev[rug_pkg::SRC_FABRIC] = sys_s[0] && !st.src_q[rug_pkg::SRC_FABRIC];
		ev[rug_pkg::SRC_WDOG] = wdt_expire;
		ev[rug_pkg::SRC_STATUS] = sys_s[3] && !st.src_q[rug_pkg::SRC_STATUS];
		ev[rug_pkg::SRC_CRC] = (sys_s[4] && !st.src_q[rug_pkg::SRC_CRC]) || early_fail;
		ev[rug_pkg::SRC_CFG_PIN] = sys_s[2] && !st.src_q[rug_pkg::SRC_CFG_PIN];
	end
	assign src_one = rug_first(ev);

	// Snapshot of control and status as seen by the shift domain
	always_comb begin
		snap_now.ctrl = st.ctrl;
		if (st.mstate == rug_pkg::MS_FACTORY) begin
			snap_now.cur_status = {st.mstate, 6'h00, st.boot_address};
		end else begin
			snap_now.cur_status = {st.mstate, st.ctrl.watchdog_enable_bit, wdt_limit};
		end
		snap_now.prev1 = st.prev1;
		snap_now.prev2 = st.prev2;
		snap_now.prev_valid = st.prev_valid;
		snap_now.factory = (st.mstate == rug_pkg::MS_FACTORY);
	end

	// Oscillator domain: control, status, master state, watchdog
	always_comb begin
		next_st = st;
		next_st.reconfig = 1'b0;
		next_st.src_q = {sys_s[4], sys_s[4], sys_s[3], 1'b0, sys_s[0]};
		next_st.src_q[rug_pkg::SRC_CFG_PIN] = sys_s[2];
		next_st.src_q[rug_pkg::SRC_CRC] = sys_s[4];
		if (!st.strap_done) begin
			// Strap is taken on the first edge after reset release
			next_st.strap_done = 1'b1;
			if (strap_s) begin
				next_st.factory_addr = rug_pkg::PARALLEL_FACTORY_ADDR;
			end else begin
				next_st.factory_addr = rug_pkg::SERIAL_FACTORY_ADDR;
			end
			next_st.ctrl.boot_address_field = next_st.factory_addr[23:2];
			next_st.boot_address = next_st.factory_addr;
		end else if (factory_address_set_instr_i && strap_s) begin
			next_st.factory_addr = factory_address_i;
		end
		if (sys_s[7] != st.upd_seen) begin
			// Update word is held steady by the shift side while its toggle travels
			next_st.update_copy = lk.update;
			next_st.upd_seen = sys_s[7];
		end
		if ((st.mstate == rug_pkg::MS_APP_USER) && st.ctrl.watchdog_enable_bit && !sys_s[1]) begin
			next_st.wdt_cnt = 29'(st.wdt_cnt + 29'h1);
		end else begin
			next_st.wdt_cnt = '0;
		end
		case (st.mstate)
			rug_pkg::MS_APP_LOAD: begin
				if (sys_s[5]) begin
					next_st.mstate = rug_pkg::MS_APP_USER;
				end
			end
			rug_pkg::MS_FACTORY, rug_pkg::MS_APP_USER: begin
			end
			default: begin
				next_st.mstate = rug_pkg::MS_FACTORY;
			end
		endcase
		if (|ev) begin
			next_st.prev2 = st.prev1;
			next_st.prev1 = {src_one, st.mstate, st.boot_address};
			next_st.prev_valid = st.prev_valid || (st.mstate != rug_pkg::MS_FACTORY);
			next_st.ctrl = st.update_copy;
			next_st.reconfig = 1'b1;
			next_st.wdt_cnt = '0;
			if ((st.mstate == rug_pkg::MS_FACTORY) && (src_one == 5'h01)) begin
				next_st.mstate = rug_pkg::MS_APP_LOAD;
				next_st.boot_address = {st.update_copy.boot_address_field,
					rug_pkg::ADDR_PAD};
			end else begin
				// Any error, or a request from an application, falls back to factory
				next_st.mstate = rug_pkg::MS_FACTORY;
				next_st.boot_address = st.factory_addr;
			end
		end
		// A new snapshot goes out only after the last one has been acknowledged
		if ((sys_s[8] == st.snap_tog) && (snap_now != st.snap)) begin
			next_st.snap = snap_now;
			next_st.snap_tog = !st.snap_tog;
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.ctrl <= rug_pkg::CTRL_RST;
			st.update_copy <= rug_pkg::CTRL_RST;
		end else begin
			st <= next_st;
		end
	end

	// User clock domain: shift and update registers
	always_comb begin
		next_lk = lk;
		if (link_snap_tog != lk.snap_seen) begin
			next_lk.snap = st.snap;
			next_lk.snap_seen = link_snap_tog;
		end
		if (shift_or_load_select_i) begin
			next_lk.shift = {upgrade_serial_in_i, lk.shift[38:1]};
		end else if (capture_or_update_select_i) begin
			case (capture_source_i)
				rug_pkg::RD_CONFIG: begin
					if (lk.snap.factory) begin
						next_lk.shift = lk.update;
					end else begin
						next_lk.shift = lk.snap.ctrl;
					end
				end
				rug_pkg::RD_CURRENT: begin
					next_lk.shift = {7'h00, lk.snap.cur_status};
				end
				rug_pkg::RD_PREV1: begin
					next_lk.shift = lk.snap.prev_valid ? {8'h00, lk.snap.prev1}
						: rug_pkg::BAD_CAPTURE;
				end
				default: begin
					next_lk.shift = lk.snap.prev_valid ? {8'h00, lk.snap.prev2}
						: rug_pkg::BAD_CAPTURE;
				end
			endcase
		end else if (lk.snap.factory) begin
			next_lk.update = lk.shift;
			next_lk.upd_tog = !lk.upd_tog;
		end
	end

	always_ff @(posedge upgrade_shift_clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lk <= '0;
			lk.update <= rug_pkg::CTRL_RST;
			lk.snap.factory <= 1'b1;
		end else begin
			lk <= next_lk;
		end
	end

	assign upgrade_serial_out_o = lk.shift[0];
	assign boot_address_o = st.boot_address;
	assign reconfig_start_o = st.reconfig;
	assign factory_mode_o = (st.mstate == rug_pkg::MS_FACTORY);
	assign watchdog_enable_o = st.ctrl[rug_pkg::WDEN_BIT];
	assign early_check_enable_o = st.ctrl.early_done_check_bit;
	assign startup_clk_internal_o = st.ctrl.osc_int_bit;

	// Checks, user clock domain
	sequence s_config_read;
		!shift_or_load_select_i && capture_or_update_select_i
			&& (capture_source_i == rug_pkg::RD_CONFIG);
	endsequence
	sequence s_update_op;
		!shift_or_load_select_i && !capture_or_update_select_i;
	endsequence

	a_update_blocked: assert property (@(posedge upgrade_shift_clock_i) disable iff (sys_rst_i)
		s_update_op and !lk.snap.factory |=> $stable(lk.update))
		else $error("update register changed in application configuration");
	a_update_write: assert property (@(posedge upgrade_shift_clock_i) disable iff (sys_rst_i)
		s_update_op and lk.snap.factory |=> lk.update == $past(lk.shift))
		else $error("update register missed shifted value");
	a_read_control: assert property (@(posedge upgrade_shift_clock_i) disable iff (sys_rst_i)
		s_config_read and !lk.snap.factory |=> lk.shift == $past(lk.snap.ctrl))
		else $error("application read did not load control");
	a_read_update: assert property (@(posedge upgrade_shift_clock_i) disable iff (sys_rst_i)
		s_config_read and lk.snap.factory |=> lk.shift == $past(lk.update))
		else $error("factory read did not load update");
	a_status_capture: assert property (@(posedge upgrade_shift_clock_i) disable iff (sys_rst_i)
		!shift_or_load_select_i && capture_or_update_select_i
			&& (capture_source_i == rug_pkg::RD_CURRENT)
		|=> lk.shift == {7'h00, $past(lk.snap.cur_status)})
		else $error("capture did not load status");
	a_shift_step: assert property (@(posedge upgrade_shift_clock_i) disable iff (sys_rst_i)
		shift_or_load_select_i |=> lk.shift[38] == $past(upgrade_serial_in_i)
			&& upgrade_serial_out_o == $past(lk.shift[1]))
		else $error("shift register did not move one place");

	// Checks, oscillator domain
	sequence s_reconf;
		st.reconfig;
	endsequence

	a_ctrl_copy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_reconf |-> st.ctrl == $past(st.update_copy))
		else $error("control not loaded from update at reconfiguration");
	a_status_record: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(|ev) |=> st.reconfig && (st.prev1.src == $past(src_one)) && (st.prev1.src != 5'h00))
		else $error("status not written on reconfiguration source");
	a_src_priority: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		ev[rug_pkg::SRC_CFG_PIN] && ev[rug_pkg::SRC_FABRIC] |=> st.prev1.src == 5'h10)
		else $error("tie not resolved to higher source");
	a_wdt_timeout: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		wdt_expire && (ev == 5'h02) |-> st.wdt_cnt == {st.ctrl.watchdog_timeout_field, 17'h00008}
			##1 st.reconfig && (st.prev1.src == 5'h02) && factory_mode_o)
		else $error("watchdog timeout not taken at its count");
	a_boot_addr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_reconf and (st.mstate == rug_pkg::MS_APP_LOAD)
		|-> boot_address_o == {st.ctrl.boot_address_field, 2'b00})
		else $error("boot address not field with two zero bits");
	a_powerup_addr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		st.strap_done && !$past(st.strap_done)
		|-> boot_address_o == (strap_s ? 24'h010000 : 24'h000000))
		else $error("power-up factory address wrong for scheme");
	a_early_check: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		early_fail |=> factory_mode_o && st.reconfig && (boot_address_o == st.factory_addr))
		else $error("early check failure did not reload factory image");
endmodule
`default_nettype wire

/* File: sim/rug_user_model.sv */
// Behavioural fabric user logic driving the serial upgrade port
`timescale 1ns/1ps
`default_nettype none
module rug_user_model (
	// Serial port towards the core
	output logic shift_clk_o,
	output logic serial_in_o,
	output logic shift_sel_o,
	output logic capt_sel_o,
	output logic [1:0] src_o,
	input wire logic serial_out_i
);
	// Clock stands still between frames, as a fabric master may stop it
	initial begin
		shift_clk_o = 1'h0;
		serial_in_o = 1'h0;
		shift_sel_o = 1'h1;
		capt_sel_o = 1'h1;
		src_o = 2'h0;
	end
	// One 32 ns cycle, under the 40 MHz ceiling
	task automatic cyc(input logic sh, input logic cp, input logic d);
		shift_sel_o = sh;
		capt_sel_o = cp;
		serial_in_o = d;
		#16 shift_clk_o = 1'h1;
		// Data turns over after its sampling edge so stale values never pass
		#8 serial_in_o = ~d;
		#8 shift_clk_o = 1'h0;
	endtask
	task automatic shift_word(input logic [38:0] din, output logic [38:0] dout);
		for (int i = 0; i < 39; i++) begin
			dout[i] = serial_out_i;
			cyc(1'h1, 1'h1, din[i]);
		end
	endtask
	// Update only ever follows a full shifted word
	task automatic write_upd(input logic [38:0] w);
		logic [38:0] junk;
		shift_word(w, junk);
		cyc(1'h0, 1'h0, 1'h0);
	endtask
	// Dummy shifts give the snapshot time to cross before the capture
	task automatic read(input logic [1:0] src, output logic [38:0] q);
		repeat (8) cyc(1'h1, 1'h1, 1'h0);
		src_o = src;
		cyc(1'h0, 1'h1, 1'h0);
		shift_word(39'h0, q);
	endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the remote upgrade register core
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic [38:0] w;
		logic [2:0] ev;
		logic [4:0] src;
	} rug_row_t;
	// Word written by factory logic, event that ends the application, expected source
	localparam rug_row_t rows [7] = '{
		'{39'h38_0001_2abc, 3'h0, 5'h10},
		'{39'h40_1234_5fff, 3'h1, 5'h08},
		'{39'h00_3fff_f000, 3'h2, 5'h04},
		'{39'h28_0040_0000, 3'h3, 5'h02},
		'{39'h10_0000_1001, 3'h4, 5'h01},
		'{39'h20_00ab_c000, 3'h5, 5'h08},
		'{39'h30_0fed_c123, 3'h6, 5'h10}
	};
	logic clk, rst, cfg_n, stat_n, crc, cc, fail, fab_n, wd_n, par, fas;
	logic [23:0] faddr;
	logic sck, sin, ssel, csel, sout, fmode, wden, early, oscint, start;
	logic [1:0] src;
	logic [1:0] st;
	logic [23:0] boot;
	logic [38:0] q;
	int errors = 0;
	int total_checks = 0;

	rug_user_model m (
		.shift_clk_o(sck), .serial_in_o(sin), .shift_sel_o(ssel),
		.capt_sel_o(csel), .src_o(src), .serial_out_i(sout)
	);
	rug_core uut (
		.sys_clk_i(clk), .sys_rst_i(rst), .upgrade_shift_clock_i(sck),
		.upgrade_serial_in_i(sin), .shift_or_load_select_i(ssel),
		.capture_or_update_select_i(csel), .capture_source_i(src),
		.upgrade_serial_out_o(sout), .fabric_reconfig_request_n_i(fab_n),
		.watchdog_restart_n_i(wd_n), .config_reset_pin_n_i(cfg_n),
		.config_status_line_n_i(stat_n), .crc_error_i(crc), .config_complete_pin_i(cc),
		.image_check_fail_i(fail), .parallel_flash_scheme_i(par),
		.factory_address_set_instr_i(fas), .factory_address_i(faddr),
		.boot_address_o(boot), .reconfig_start_o(start), .factory_mode_o(fmode),
		.watchdog_enable_o(wden), .early_check_enable_o(early), .startup_clk_internal_o(oscint)
	);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic results;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [38:0] exp, input logic [38:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic outs(input logic [23:0] b, input logic fm, input logic [2:0] opt);
		chk("boot address", 39'(b), 39'(boot));
		chk("factory mode", 39'(fm), 39'(fmode));
		chk("option bits", 39'(opt), 39'({early, oscint, wden}));
	endtask
	// Bounded wait; a missing pulse ends the run
	task automatic wait_start;
		int n = 0;
		while (start !== 1'h1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n == 100) begin
			errors++;
			$display("wrong value reconfig start: expected 1, seen 0");
			results();
		end
	endtask
	task automatic fire(input logic [2:0] ev);
		@(negedge clk);
		case (ev)
			3'h0: cfg_n = 1'h0;
			3'h1: crc = 1'h1;
			3'h2: stat_n = 1'h0;
			3'h3: wd_n = 1'h1;
			3'h4: fab_n = 1'h0;
			3'h5: fail = 1'h1;
			3'h6: begin
				cfg_n = 1'h0;
				fab_n = 1'h0;
			end
			default: ;
		endcase
		wait_start();
		@(negedge clk);
		{cfg_n, crc, stat_n, wd_n, fab_n, fail} = 6'h2a;
		repeat (10) @(negedge clk);
	endtask

	initial begin
		rst = 1'h1;
		// Idle: restart held low so the watchdog only runs when a scenario lets go of it
		{cfg_n, crc, stat_n, wd_n, fab_n, fail} = 6'h2a;
		cc = 1'h0;
		par = 1'h0;
		fas = 1'h0;
		faddr = 24'h000000;
		m.cyc(1'h1, 1'h1, 1'h0);
		m.cyc(1'h1, 1'h1, 1'h0);
		@(negedge clk);
		rst = 1'h0;
		outs(24'h000000, 1'h1, 3'h7);
		repeat (5) @(negedge clk);
		foreach (rows[i]) begin
			st = (rows[i].ev == 3'h5) ? 2'h1 : 2'h3;
			m.write_upd(rows[i].w);
			m.read(2'h0, q);
			chk("update", rows[i].w, q);
			fire(3'h4);
			outs({rows[i].w[33:12], rug_pkg::ADDR_PAD}, 1'h0, rows[i].w[37:35]);
			cc = (rows[i].ev != 3'h5);
			repeat (10) @(negedge clk);
			m.read(2'h0, q);
			chk("control", rows[i].w, q);
			m.read(2'h1, q);
			chk("status", {7'h0, st, rows[i].w[35], rows[i].w[11:0], rug_pkg::WDT_LOW}, q);
			m.write_upd(~rows[i].w);
			fire(rows[i].ev);
			cc = 1'h0;
			outs(24'h000000, 1'h1, rows[i].w[37:35]);
			m.read(2'h2, q);
			chk("previous", {8'h0, rows[i].src, st, rows[i].w[33:12], rug_pkg::ADDR_PAD}, q);
			m.read(2'h3, q);
			chk("previous two", {8'h00, 5'h01, 2'h0, 24'h000000}, q);
			m.read(2'h0, q);
			chk("refused update", rows[i].w, q);
		end
		// Second reset in the middle of an application, this time on the parallel scheme
		fire(3'h4);
		rst = 1'h1;
		par = 1'h1;
		m.cyc(1'h1, 1'h1, 1'h0);
		m.cyc(1'h1, 1'h1, 1'h0);
		outs(24'h000000, 1'h1, 3'h7);
		@(negedge clk);
		rst = 1'h0;
		repeat (5) @(negedge clk);
		outs(rug_pkg::PARALLEL_FACTORY_ADDR, 1'h1, 3'h7);
		m.read(2'h3, q);
		chk("early previous", rug_pkg::BAD_CAPTURE, q);
		m.read(2'h0, q);
		chk("update after reset", rug_pkg::CTRL_RST, q);
		// A new factory address only shows at the next fall-back
		@(negedge clk);
		fas = 1'h1;
		faddr = 24'h5aa5a4;
		@(negedge clk);
		fas = 1'h0;
		fire(3'h4);
		outs(24'h000000, 1'h0, 3'h7);
		fire(3'h4);
		outs(24'h5aa5a4, 1'h1, 3'h7);
		results();
	end
endmodule
`default_nettype wire
